/* verilog/ssr_pkg.sv */
// Constants, field layout and bus carrier for the event router
package ssr_pkg;

    // ----------------------------------------------------------------
    // Event indices in the status and enable registers
    // ----------------------------------------------------------------
    localparam int N_EV            = 17;
    localparam int EV_BUTTON       = 0;
    localparam int EV_OVERRIDE     = 1;
    localparam int EV_PM_TIMER     = 2;
    localparam int EV_PERIODIC     = 3;
    localparam int EV_SW_TIMER     = 4;
    localparam int EV_PM_CMD       = 5;
    localparam int EV_PCIE_PME     = 6;
    localparam int EV_HOT_PLUG     = 7;
    localparam int EV_TCO_CTRL     = 8;
    localparam int EV_INTRUSION    = 9;
    localparam int EV_FW_WRITE     = 10;
    localparam int EV_SLEEP_TRAP   = 11;
    localparam int EV_GPIO_UNLOCK  = 12;
    localparam int EV_SMBUS        = 13;
    localparam int EV_HOST_NOTIFY  = 14;
    localparam int EV_NMI_REDIRECT = 15;
    localparam int EV_GLOBAL       = 16;

    // Which events can reach each interrupt, and which need an enable
    localparam logic [16:0] SMI_CAP = 17'h0fe3d;
    localparam logic [16:0] SCI_CAP = 17'h101c7;
    localparam logic [16:0] EN_REQ  = 17'h1d8fd;

    // ----------------------------------------------------------------
    // Register offsets (byte addresses)
    // ----------------------------------------------------------------
    localparam logic [7:0] REG_STATUS  = 8'h00;
    localparam logic [7:0] REG_ENABLE  = 8'h04;
    localparam logic [7:0] REG_CONTROL = 8'h08;
    localparam logic [7:0] REG_STATE   = 8'h0c;

    // Control register fields
    localparam int CTL_SELECT    = 0;
    localparam int CTL_GBL_EN    = 1;
    localparam int CTL_EOS       = 2;
    localparam int CTL_FW_RLS    = 3;
    localparam int CTL_FWE       = 4;
    localparam int CTL_FLE       = 5;
    localparam int CTL_SLEEP     = 6;
    localparam int CTL_GPIO_LOCK = 7;
    localparam int CTL_INTR_SEL  = 8;
    localparam int CTL_APIC      = 10;
    localparam int CTL_LINE      = 11;

    // ----------------------------------------------------------------
    // Reset values and encodings
    // ----------------------------------------------------------------
    localparam logic [16:0] STATUS_RST  = 17'h00000;
    localparam logic [16:0] ENABLE_RST  = 17'h00000;
    localparam logic        EOS_RST     = 1'b1;
    localparam logic [4:0]  LINE_RST    = 5'h09;
    localparam logic [4:0]  LINE_LO_MIN = 5'h09;
    localparam logic [4:0]  LINE_LO_MAX = 5'h0b;
    localparam logic [4:0]  LINE_HI_MIN = 5'h14;
    localparam logic [4:0]  LINE_HI_MAX = 5'h17;
    localparam logic [1:0]  INTR_SEL_MGMT = 2'h2;
    localparam logic [15:0] PM_CMD_PORT = 16'h00b2;

    // ----------------------------------------------------------------
    // Timing
    // ----------------------------------------------------------------
    localparam int unsigned CLK_MHZ      = 200;
    localparam int unsigned PM_TIMER_US  = 2340000;
    localparam int unsigned SW_TIMER_MS  = 64;
    localparam int unsigned PERIODIC_MS  = 8;
    localparam int unsigned PM_TIMER_CYC = PM_TIMER_US * CLK_MHZ;
    localparam int unsigned SW_TIMER_CYC = SW_TIMER_MS * 1000 * CLK_MHZ;
    localparam int unsigned PERIODIC_CYC = PERIODIC_MS * 1000 * CLK_MHZ;

    // Classic Wishbone request from the master
    typedef struct packed {
        logic        cyc;
        logic        stb;
        logic        we;
        logic [7:0]  adr;
        logic [3:0]  sel;
        logic [31:0] dat;
    } ssr_wb_req_s;

endpackage : ssr_pkg

/* verilog/ssr_event_router.sv */
// Event router: management and control interrupt generation
module ssr_event_router
    import ssr_pkg::*;
#(
    parameter int unsigned PM_TIMER_CYCLES = PM_TIMER_CYC,
    parameter int unsigned PERIODIC_CYCLES = PERIODIC_CYC,
    parameter int unsigned SW_TIMER_CYCLES = SW_TIMER_CYC
) (
    input  wire logic        sys_clk,
    input  wire logic        nrst,
    input  wire ssr_wb_req_s wb_req,
    output logic             wb_ack,
    output logic [31:0]      wb_dat_o,
    input  wire logic        button_press,
    input  wire logic        button_override,
    input  wire logic        wake_s0,
    input  wire logic        pcie_pme_msg,
    input  wire logic        hot_plug_msg,
    input  wire logic        tco_control_msg,
    input  wire logic        intrusion_pin_n,
    input  wire logic        fw_write_attempt,
    input  wire logic        io_write,
    input  wire logic [15:0] io_addr,
    input  wire logic        host_notify_msg,
    input  wire logic        smbus_alert_n,
    input  wire logic        nmi_event,
    input  wire logic        nmi_mapped,
    output logic             virtual_wire_message,
    output logic             acpi_control_interrupt,
    output logic [23:0]      sci_irq_lines,
    output logic             enter_s5
);

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!nrst);

    // ----------------------------------------------------------------
    // Register state
    // ----------------------------------------------------------------
    logic [16:0] status_reg;
    logic [16:0] enable_reg;
    logic        select_reg;
    logic        gbl_en_reg;
    logic        eos_reg;
    logic        fwe_reg;
    logic        fle_reg;
    logic        gpio_lock_reg;
    logic        apic_reg;
    logic [1:0]  intr_sel_reg;
    logic [4:0]  line_reg;
    logic        s5_reg;
    logic [1:0]  pin_q1_reg;
    logic [1:0]  pin_q2_reg;
    logic [1:0]  pin_q3_reg;

    // ----------------------------------------------------------------
    // Bus decode
    // ----------------------------------------------------------------
    logic        wr_fire;
    logic [31:0] wmask;
    logic [31:0] wd;
    logic        wr_status;
    logic        wr_enable;
    logic        ctl_lo;
    logic        ctl_hi;

    assign wr_fire   = wb_req.cyc & wb_req.stb & wb_req.we & wb_ack;
    assign wmask     = {{8{wb_req.sel[3]}}, {8{wb_req.sel[2]}},
                        {8{wb_req.sel[1]}}, {8{wb_req.sel[0]}}};
    assign wd        = wb_req.dat & wmask;
    assign wr_status = wr_fire && (wb_req.adr == REG_STATUS);
    assign wr_enable = wr_fire && (wb_req.adr == REG_ENABLE);
    assign ctl_lo    = wr_fire && (wb_req.adr == REG_CONTROL)
                       && wb_req.sel[0];
    assign ctl_hi    = wr_fire && (wb_req.adr == REG_CONTROL)
                       && wb_req.sel[1];

    // ----------------------------------------------------------------
    // Pin synchronisers, bit 0 intrusion, bit 1 SMBus alert
    // ----------------------------------------------------------------
    logic [1:0] pin_fall;

    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            pin_q1_reg <= 2'h3;
            pin_q2_reg <= 2'h3;
            pin_q3_reg <= 2'h3;
        end else begin
            pin_q1_reg <= {smbus_alert_n, intrusion_pin_n};
            pin_q2_reg <= pin_q1_reg;
            pin_q3_reg <= pin_q2_reg;
        end
    end

    assign pin_fall = pin_q3_reg & ~pin_q2_reg;

    // ----------------------------------------------------------------
    // Free-running timers: ACPI, periodic, software
    // ----------------------------------------------------------------
    localparam int unsigned TMR_CYC [3] = '{PM_TIMER_CYCLES,
                                            PERIODIC_CYCLES,
                                            SW_TIMER_CYCLES};
    logic [2:0] tmr_expire;

    for (genvar i = 0; i < 3; i++) begin : g_tmr
        logic [31:0] cnt_reg;
        assign tmr_expire[i] = (cnt_reg == 32'(TMR_CYC[i] - 1));
        always_ff @(posedge sys_clk) begin
            if (!nrst) begin
                cnt_reg <= 32'h0;
            end else if (tmr_expire[i]) begin
                cnt_reg <= 32'h0;
            end else begin
                cnt_reg <= cnt_reg + 32'h1;
            end
        end
    end

    // ----------------------------------------------------------------
    // Event capture
    // ----------------------------------------------------------------
    logic [16:0] ev_set;

    always_comb begin
        ev_set                  = '0;
        ev_set[EV_BUTTON]       = button_press;
        ev_set[EV_OVERRIDE]     = button_override;
        ev_set[EV_PM_TIMER]     = tmr_expire[0];
        ev_set[EV_PERIODIC]     = tmr_expire[1];
        ev_set[EV_SW_TIMER]     = tmr_expire[2];
        ev_set[EV_PM_CMD]       = io_write
                                  && (io_addr == PM_CMD_PORT);
        ev_set[EV_PCIE_PME]     = pcie_pme_msg;
        ev_set[EV_HOT_PLUG]     = hot_plug_msg;
        ev_set[EV_TCO_CTRL]     = tco_control_msg;
        ev_set[EV_INTRUSION]    = pin_fall[0]
                                  && (intr_sel_reg == INTR_SEL_MGMT);
        ev_set[EV_FW_WRITE]     = (ctl_lo && wd[CTL_FWE] && !fwe_reg
                                   && fle_reg)
                                  || (fw_write_attempt && fwe_reg);
        ev_set[EV_SLEEP_TRAP]   = ctl_lo && wd[CTL_SLEEP];
        ev_set[EV_GPIO_UNLOCK]  = ctl_lo && gpio_lock_reg
                                  && !wd[CTL_GPIO_LOCK]
                                  && enable_reg[EV_GPIO_UNLOCK];
        ev_set[EV_SMBUS]        = host_notify_msg || pin_fall[1];
        ev_set[EV_HOST_NOTIFY]  = host_notify_msg;
        ev_set[EV_NMI_REDIRECT] = nmi_event && nmi_mapped
                                  && enable_reg[EV_NMI_REDIRECT];
        ev_set[EV_GLOBAL]       = ctl_lo && wd[CTL_FW_RLS];
    end

    // Set wins over a same-cycle write-one clear
    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            status_reg <= STATUS_RST;
        end else if (wr_status) begin
            status_reg <= (status_reg & ~wd[16:0]) | ev_set;
        end else begin
            status_reg <= status_reg | ev_set;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            enable_reg <= ENABLE_RST;
        end else if (wr_enable) begin
            enable_reg <= (enable_reg & ~wmask[16:0]) | wd[16:0];
        end
    end

    // ----------------------------------------------------------------
    // Control register
    // ----------------------------------------------------------------
    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            select_reg    <= 1'b0;
            gbl_en_reg    <= 1'b0;
            fwe_reg       <= 1'b0;
            fle_reg       <= 1'b0;
            gpio_lock_reg <= 1'b0;
        end else if (ctl_lo) begin
            select_reg    <= wd[CTL_SELECT];
            gbl_en_reg    <= wd[CTL_GBL_EN];
            fwe_reg       <= wd[CTL_FWE];
            fle_reg       <= wd[CTL_FLE];
            gpio_lock_reg <= wd[CTL_GPIO_LOCK];
        end
    end

    logic [4:0] line_wr;
    logic       apic_wr;
    logic       line_ok;

    assign line_wr = wd[CTL_LINE +: 5];
    assign apic_wr = wd[CTL_APIC];
    assign line_ok = (line_wr >= LINE_LO_MIN && line_wr <= LINE_LO_MAX)
                     || (apic_wr && line_wr >= LINE_HI_MIN
                         && line_wr <= LINE_HI_MAX);

    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            intr_sel_reg <= 2'h0;
            apic_reg     <= 1'b0;
            line_reg     <= LINE_RST;
        end else if (ctl_hi) begin
            intr_sel_reg <= wd[CTL_INTR_SEL +: 2];
            apic_reg     <= apic_wr;
            if (line_ok) begin
                line_reg <= line_wr;
            end else if (!apic_wr && line_reg >= LINE_HI_MIN) begin
                line_reg <= LINE_RST;
            end
        end
    end

    // ----------------------------------------------------------------
    // Interrupt sources
    // ----------------------------------------------------------------
    logic [16:0] eff;
    logic        smi_src;
    logic        smi_pending;
    logic        sci_next;

    assign eff = status_reg & (enable_reg | ~EN_REQ);
    // Alert-only SMBus status needs no enable; notify needs none either, via its SMBus bit
    assign smi_src = |(eff & SMI_CAP)
                     || (status_reg[EV_SMBUS]
                         && !status_reg[EV_HOST_NOTIFY]);
    assign smi_pending = smi_src && gbl_en_reg && !select_reg;
    assign sci_next = !s5_reg
                      && ((select_reg && |(eff & SCI_CAP))
                          || eff[EV_GLOBAL]);

    // ----------------------------------------------------------------
    // Management interrupt delivery
    // ----------------------------------------------------------------
    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            eos_reg <= EOS_RST;
        end else if (ctl_lo && wd[CTL_EOS]) begin
            eos_reg <= 1'b1;
        end else if (smi_pending && eos_reg) begin
            eos_reg <= 1'b0;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            virtual_wire_message <= 1'b0;
        end else begin
            virtual_wire_message <= smi_pending && eos_reg;
        end
    end

    // ----------------------------------------------------------------
    // Override sleep and control interrupt level
    // ----------------------------------------------------------------
    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            s5_reg   <= 1'b0;
            enter_s5 <= 1'b0;
        end else begin
            enter_s5 <= button_override;
            if (button_override) begin
                s5_reg <= 1'b1;
            end else if (wake_s0) begin
                s5_reg <= 1'b0;
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            acpi_control_interrupt <= 1'b0;
            sci_irq_lines          <= 24'h0;
        end else begin
            acpi_control_interrupt <= sci_next;
            sci_irq_lines <= sci_next ? (24'h1 << line_reg) : 24'h0;
        end
    end

    // ----------------------------------------------------------------
    // Wishbone answer
    // ----------------------------------------------------------------
    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            wb_ack   <= 1'b0;
            wb_dat_o <= 32'h0;
        end else begin
            wb_ack <= wb_req.cyc && wb_req.stb && !wb_ack;
            case (wb_req.adr)
                REG_STATUS:  wb_dat_o <= {15'h0, status_reg};
                REG_ENABLE:  wb_dat_o <= {15'h0, enable_reg};
                REG_CONTROL: wb_dat_o <= {16'h0, line_reg, apic_reg,
                                          intr_sel_reg, gpio_lock_reg,
                                          1'b0, fle_reg, fwe_reg, 1'b0,
                                          eos_reg, gbl_en_reg, select_reg};
                REG_STATE:   wb_dat_o <= {28'h0, s5_reg, smi_pending,
                                          virtual_wire_message,
                                          acpi_control_interrupt};
                default:     wb_dat_o <= 32'h0;
            endcase
        end
    end

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    chk_sci_select_gate: assert property (
        acpi_control_interrupt && !$past(eff[EV_GLOBAL]) |-> $past(select_reg))
        else $error("control interrupt without select");
    chk_smi_select_gate: assert property (
        virtual_wire_message |-> $past(!select_reg))
        else $error("management message while select set");
    chk_smi_global_gate: assert property (
        virtual_wire_message |-> $past(gbl_en_reg) && $past(smi_src))
        else $error("management message without global enable");
    chk_eos_rearm_wait: assert property (
        virtual_wire_message && !(ctl_lo && wd[CTL_EOS])
        ##1 !(ctl_lo && wd[CTL_EOS])
        |=> !virtual_wire_message)
        else $error("second message without end-of-service");
    chk_eos_clear_send: assert property (
        smi_pending && eos_reg && !(ctl_lo && wd[CTL_EOS])
        |=> virtual_wire_message && !eos_reg)
        else $error("pending event not delivered");
    chk_line_legal_set: assert property (
        (line_reg >= LINE_LO_MIN && line_reg <= LINE_LO_MAX)
        || (apic_reg && line_reg >= LINE_HI_MIN && line_reg <= LINE_HI_MAX)
        || $past(ctl_hi))
        else $error("control line outside legal range");
    chk_override_enter_s5: assert property (
        button_override |=> enter_s5 && s5_reg ##1 !acpi_control_interrupt)
        else $error("override did not enter S5");
    chk_release_global_irq: assert property (
        ctl_lo && wd[CTL_FW_RLS] && enable_reg[EV_GLOBAL] && !s5_reg
        && !button_override |=> ##1 acpi_control_interrupt)
        else $error("release did not raise control interrupt");
    chk_port_cmd_status: assert property (
        io_write && io_addr == PM_CMD_PORT |=> status_reg[EV_PM_CMD])
        else $error("port write did not set command status");
    chk_sci_level_hold: assert property (
        sci_next |=> acpi_control_interrupt
        && sci_irq_lines == (24'h1 << $past(line_reg)))
        else $error("control interrupt level not held");
    chk_status_set_wins: assert property (
        wr_status && ev_set[EV_BUTTON] |=> status_reg[EV_BUTTON])
        else $error("set lost against clear");

    cov_smi_delivered: cover property (virtual_wire_message);
    cov_sci_apic_line: cover property (acpi_control_interrupt
                                       && line_reg >= LINE_HI_MIN);
    cov_override_wake: cover property (s5_reg ##1 !s5_reg);
    cov_eos_rearm: cover property (virtual_wire_message ##[1:20]
                                   virtual_wire_message);

endmodule : ssr_event_router

/* tb/ssr_host_model.sv */
// Host processor and interrupt controller seen from the router
module ssr_host_model (
    input  wire logic        sys_clk,
    input  wire logic        virtual_wire_message,
    input  wire logic        acpi_control_interrupt,
    input  wire logic [23:0] sci_irq_lines,
    output int               n_msg,
    output logic             line_bad
);
    timeunit 1ns;
    timeprecision 1ps;
    initial n_msg = 0;
    // Handler entry per wire message
    always @(posedge sys_clk) begin
        if (virtual_wire_message === 1'b1) n_msg <= n_msg + 1;
    end
    // Level input: active line must be the only one high
    assign line_bad = acpi_control_interrupt
                      && !$onehot(sci_irq_lines);
endmodule : ssr_host_model

/* tb/ssr_event_router_tb_top.sv */
// Self-checking bench for the event router
module ssr_event_router_tb_top;
    import ssr_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    logic        sys_clk, nrst, wb_ack, vw, acpi, enter_s5, line_bad;
    logic        pin_n, nmi_mapped, s5_seen;
    logic [31:0] wb_dat_o, r, d;
    logic [23:0] lines;
    logic [15:0] io_addr;
    logic [9:0]  ev;
    ssr_wb_req_s req;
    int          n_fail, checked, n_msg, seed;

    ssr_event_router #(.PM_TIMER_CYCLES(50), .PERIODIC_CYCLES(70),
        .SW_TIMER_CYCLES(30)) dut (
        .sys_clk(sys_clk), .nrst(nrst), .wb_req(req), .wb_ack(wb_ack),
        .wb_dat_o(wb_dat_o), .button_press(ev[0]), .button_override(ev[1]),
        .wake_s0(ev[2]), .pcie_pme_msg(ev[3]), .hot_plug_msg(ev[4]),
        .tco_control_msg(ev[5]), .intrusion_pin_n(pin_n),
        .fw_write_attempt(ev[6]), .io_write(ev[7]), .io_addr(io_addr),
        .host_notify_msg(ev[8]), .smbus_alert_n(pin_n), .nmi_event(ev[9]),
        .nmi_mapped(nmi_mapped), .virtual_wire_message(vw),
        .acpi_control_interrupt(acpi), .sci_irq_lines(lines),
        .enter_s5(enter_s5));
    ssr_host_model host (.sys_clk(sys_clk), .virtual_wire_message(vw),
        .acpi_control_interrupt(acpi), .sci_irq_lines(lines),
        .n_msg(n_msg), .line_bad(line_bad));

    initial begin
        sys_clk = 1'b0;
        forever #2.5 sys_clk = ~sys_clk;
    end

    task automatic chk(input string name, input logic [31:0] exp, got);
        checked++;
        if (got !== exp) begin
            n_fail++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
        end
    endtask : chk

    task automatic wb(input logic we, input logic [7:0] a,
                      input logic [31:0] dat);
        req <= '{1'b1, 1'b1, we, a, 4'hf, dat};
        do begin
            @(posedge sys_clk);
        end while (wb_ack !== 1'b1);
        r = wb_dat_o;
        req <= '0;
        @(posedge sys_clk);
    endtask : wb

    task automatic pulse(input logic [9:0] m);
        ev <= m;
        @(posedge sys_clk);
        ev <= '0;
        repeat (3) @(posedge sys_clk);
    endtask : pulse

    task automatic close_out;
        $display("checked %0d failed %0d", checked, n_fail);
        if (n_fail == 0 && checked > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : close_out

    always @(posedge sys_clk) begin
        if (enter_s5 === 1'b1) s5_seen <= 1'b1;
        if (line_bad === 1'b1) begin
            n_fail++;
            $display("CHECK FAILED line onehot expected 1 seen 0");
        end
    end

    initial begin
        #50000;
        n_fail++;
        close_out();
    end

    initial begin
        seed = 45031;
        nrst = 1'b0;
        req = '0;
        ev = '0;
        io_addr = PM_CMD_PORT;
        pin_n = 1'b1;
        nmi_mapped = 1'b0;
        s5_seen = 1'b0;
        repeat (20) @(posedge sys_clk);
        nrst <= 1'b1;
        @(posedge sys_clk);
        wb(1'b0, REG_CONTROL, '0);
        chk("control", 32'h4804, r);
        wb(1'b0, 8'h10, '0);
        chk("unmapped", 32'h0, r);
        repeat (80) @(posedge sys_clk);
        wb(1'b0, REG_STATUS, '0);
        chk("timers", 32'h1c, r & 32'h1c);
        for (int i = 0; i < 4; i++) begin
            d = $random(seed) & 32'h1ffff;
            wb(1'b1, REG_ENABLE, d);
            wb(1'b0, REG_ENABLE, '0);
            chk("enable", d, r);
        end
        $display("reset, timers and enables done");
        wb(1'b1, REG_ENABLE, 32'h10060);
        pulse(10'h080);
        chk("gated", 32'h0, n_msg);
        wb(1'b1, REG_STATUS, 32'h20);
        // Management enabled after the gated trap, before the next trap is used
        wb(1'b1, REG_CONTROL, 32'h4802);
        pulse(10'h080);
        chk("first", 32'h1, n_msg);
        pulse(10'h080);
        chk("no rearm", 32'h1, n_msg);
        wb(1'b1, REG_CONTROL, 32'h4806);
        repeat (3) @(posedge sys_clk);
        chk("resend", 32'h2, n_msg);
        wb(1'b1, REG_STATUS, 32'h20);
        $display("management path done");
        wb(1'b1, REG_CONTROL, 32'h4807);
        pulse(10'h088);
        chk("level", 32'h1, acpi);
        chk("line 9", 32'h200, lines);
        chk("blocked", 32'h2, n_msg);
        wb(1'b1, REG_STATUS, 32'h60);
        repeat (2) @(posedge sys_clk);
        chk("cleared", 32'h0, acpi);
        wb(1'b1, REG_CONTROL, 32'ha407);
        pulse(10'h008);
        chk("line 20", 32'h100000, lines);
        wb(1'b1, REG_CONTROL, 32'ha007);
        wb(1'b0, REG_CONTROL, '0);
        chk("line back", 32'h9, (r >> 11) & 32'h1f);
        wb(1'b1, REG_STATUS, 32'h40);
        wb(1'b1, REG_CONTROL, 32'h480a);
        repeat (2) @(posedge sys_clk);
        chk("release", 32'h1, acpi);
        wb(1'b0, REG_STATUS, '0);
        chk("global", 32'h10000, r & 32'h10000);
        wb(1'b1, REG_STATUS, 32'h10000);
        wb(1'b1, REG_CONTROL, 32'h4801);
        pulse(10'h002);
        chk("s5 entry", 32'h1, s5_seen);
        chk("held", 32'h0, acpi);
        pulse(10'h004);
        chk("wake", 32'h1, acpi);
        wb(1'b1, REG_STATUS, 32'h2);
        repeat (2) @(posedge sys_clk);
        chk("override", 32'h0, acpi);
        pulse(10'h020);
        chk("processor msg", 32'h1, acpi);
        wb(1'b1, REG_STATUS, 32'h100);
        repeat (2) @(posedge sys_clk);
        chk("msg cleared", 32'h0, acpi);
        $display("control path done");
        wb(1'b1, REG_CONTROL, 32'h4806);
        pin_n <= 1'b0;
        repeat (8) @(posedge sys_clk);
        chk("alert", 32'h3, n_msg);
        wb(1'b0, REG_STATUS, '0);
        chk("alert status", 32'h2000, r & 32'h2000);
        pin_n <= 1'b1;
        $display("alert path done");
        close_out();
    end
endmodule : ssr_event_router_tb_top
